//--- rtl/mbw_consts.svh
// constants for the modbus multi-register write handler
`ifndef MBW_CONSTS_SVH
`define MBW_CONSTS_SVH

`define MBW_FC_WRITE 8'h10
`define MBW_FC_RDWR 8'h17
`define MBW_ERR_FLAG 8'h80
`define MBW_EXC_FUNC 8'h01
`define MBW_EXC_ADDR 8'h02
`define MBW_EXC_VALUE 8'h03
`define MBW_PROTO_ID 16'h0000
`define MBW_WR_LEN_BASE 16'h0007
`define MBW_RW_LEN_BASE 16'h000b
`define MBW_RD_LEN_BASE 16'h0003
`define MBW_WR_RSP_LEN 16'h0006
`define MBW_EXC_LEN 16'h0003
`define MBW_CNT_MIN 16'h0001
`define MBW_WR_MAX 16'h007b
`define MBW_RW_MAX 16'h0079
`define MBW_POS_FC 9'h007
`define MBW_POS_WR_BC 9'h00c
`define MBW_POS_RW_BC 9'h010
`define MBW_TX_EXC_END 9'h008
`define MBW_TX_WR_END 9'h00b
`define MBW_TX_DATA_POS 9'h009

`endif

//--- rtl/mbw_pkg.sv
// types shared by the modbus multi-register write handler
package mbw_pkg;

    typedef enum logic [6:0] {
        S_HDR = 7'b0000001,
        S_CHK = 7'b0000010,
        S_MAPW = 7'b0000100,
        S_MAPR = 7'b0001000,
        S_DATA = 7'b0010000,
        S_DRAIN = 7'b0100000,
        S_RESP = 7'b1000000
    } mbw_rx_state_t;

    typedef enum logic [3:0] {
        T_IDLE = 4'b0001,
        T_SEND = 4'b0010,
        T_RD = 4'b0100,
        T_LD = 4'b1000
    } mbw_tx_state_t;

endpackage : mbw_pkg

//--- rtl/mbw_rsp_if.sv
// reply descriptor passed from the request parser to the reply builder
`timescale 1ns/1ps
interface mbw_rsp_if;
    logic start;
    logic busy;
    logic err;
    logic [7:0] exc;
    logic [15:0] tid;
    logic [7:0] uid;
    logic [7:0] fc;
    logic [15:0] rd_addr;
    logic [15:0] rd_cnt;
    logic [15:0] wr_addr;
    logic [15:0] wr_cnt;

    modport parser (output start, err, exc, tid, uid, fc, rd_addr, rd_cnt, wr_addr, wr_cnt, input busy);
    modport builder (input start, err, exc, tid, uid, fc, rd_addr, rd_cnt, wr_addr, wr_cnt, output busy);
endinterface : mbw_rsp_if

//--- rtl/mbw_reply.sv
// reply builder: serialises normal and exception replies, fetches read data
`timescale 1ns/1ps
`include "mbw_consts.svh"
module mbw_reply
    import mbw_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // descriptor from parser
    mbw_rsp_if.builder rsp,
    // reply byte stream
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_last,
    input wire logic tx_ready,
    // register read port, data one cycle after enable
    output logic reg_rd_en,
    output logic [15:0] reg_rd_addr,
    input wire logic [15:0] reg_rd_data
);

    mbw_tx_state_t st_r;
    logic err_r, fresh_r;
    logic [7:0] exc_r, uid_r, fc_r, k_r;
    logic [15:0] tid_r, raddr_r, rcnt_r, waddr_r, wcnt_r, word_r, len;
    logic [8:0] idx_r, last_idx;
    logic [7:0] byte_nxt;
    logic slot_free, need_word, is_rdwr;

    assign rsp.busy = (st_r != T_IDLE);
    assign reg_rd_en = (st_r == T_RD);
    assign slot_free = !tx_valid || tx_ready;
    assign is_rdwr = !err_r && (fc_r == `MBW_FC_RDWR);
    assign need_word = is_rdwr && (idx_r >= `MBW_TX_DATA_POS) && idx_r[0] && !fresh_r;

    // reply length and last byte per reply kind
    always_comb begin
        if (err_r) begin
            len = `MBW_EXC_LEN;
            last_idx = `MBW_TX_EXC_END;
        end else if (is_rdwr) begin
            len = `MBW_RD_LEN_BASE + {7'h00, rcnt_r[7:0], 1'b0};
            last_idx = `MBW_TX_EXC_END + {rcnt_r[7:0], 1'b0};
        end else begin
            len = `MBW_WR_RSP_LEN;
            last_idx = `MBW_TX_WR_END;
        end
    end

    always_comb begin
        case (idx_r)
            9'h000: byte_nxt = tid_r[15:8];
            9'h001: byte_nxt = tid_r[7:0];
            9'h002: byte_nxt = 8'(`MBW_PROTO_ID >> 8);
            9'h003: byte_nxt = 8'(`MBW_PROTO_ID);
            9'h004: byte_nxt = len[15:8];
            9'h005: byte_nxt = len[7:0];
            9'h006: byte_nxt = uid_r;
            9'h007: byte_nxt = err_r ? (fc_r | `MBW_ERR_FLAG) : fc_r;
            9'h008: byte_nxt = err_r ? exc_r : (is_rdwr ? {rcnt_r[6:0], 1'b0} : waddr_r[15:8]);
            default: begin
                if (is_rdwr) begin
                    byte_nxt = idx_r[0] ? word_r[15:8] : word_r[7:0];
                end else begin
                    case (idx_r)
                        9'h009: byte_nxt = waddr_r[7:0];
                        9'h00a: byte_nxt = wcnt_r[15:8];
                        default: byte_nxt = wcnt_r[7:0];
                    endcase
                end
            end
        endcase
    end

    // descriptor latch so the parser may take the next frame at once
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            err_r <= 1'b0;
            exc_r <= 8'h00;
            tid_r <= 16'h0000;
            uid_r <= 8'h00;
            fc_r <= 8'h00;
            raddr_r <= 16'h0000;
            rcnt_r <= 16'h0000;
            waddr_r <= 16'h0000;
            wcnt_r <= 16'h0000;
        end else if (st_r == T_IDLE && rsp.start) begin
            err_r <= rsp.err;
            exc_r <= rsp.exc;
            tid_r <= rsp.tid;
            uid_r <= rsp.uid;
            fc_r <= rsp.fc;
            raddr_r <= rsp.rd_addr;
            rcnt_r <= rsp.rd_cnt;
            waddr_r <= rsp.wr_addr;
            wcnt_r <= rsp.wr_cnt;
        end
    end

    // sequencing, read fetch and output stage
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_r <= T_IDLE;
            idx_r <= 9'h000;
            k_r <= 8'h00;
            fresh_r <= 1'b0;
            word_r <= 16'h0000;
            reg_rd_addr <= 16'h0000;
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            tx_last <= 1'b0;
        end else begin
            if (tx_valid && tx_ready) begin
                tx_valid <= 1'b0;
            end
            case (st_r)
                T_IDLE: begin
                    idx_r <= 9'h000;
                    k_r <= 8'h00;
                    fresh_r <= 1'b0;
                    if (rsp.start) begin
                        st_r <= T_SEND;
                    end
                end
                T_SEND: begin
                    if (slot_free && need_word) begin
                        reg_rd_addr <= raddr_r + {8'h00, k_r};
                        st_r <= T_RD;
                    end else if (slot_free) begin
                        tx_valid <= 1'b1;
                        tx_data <= byte_nxt;
                        tx_last <= (idx_r == last_idx);
                        idx_r <= idx_r + 9'h001;
                        if (is_rdwr && idx_r[0]) begin
                            fresh_r <= 1'b0;
                        end
                        if (idx_r == last_idx) begin
                            st_r <= T_IDLE;
                        end
                    end
                end
                T_RD: begin
                    st_r <= T_LD;
                end
                T_LD: begin
                    word_r <= reg_rd_data;
                    fresh_r <= 1'b1;
                    k_r <= k_r + 8'h01;
                    st_r <= T_SEND;
                end
                default: st_r <= T_IDLE;
            endcase
        end
    end

endmodule : mbw_reply

//--- rtl/mbw_handler.sv
// request parser and checker for multi-register write and read/write requests
`timescale 1ns/1ps
`include "mbw_consts.svh"
// Overview of operation
// - write request stores consecutive registers from start
// - write byte count 2N, length 7+2N
// - read/write request writes then reads, one exchange
// - read count must lie in 1..0x79
// - write start, write count in 1..0x79
// - read/write ends with byte count, N values
// - read/write length field equals 0x0B+2N
// - read/write reply: code, 2M, M values
// - failures with protocol id 0 answer error code plus exception code
// - addresses accepted when mapped to user objects
module mbw_handler
    import mbw_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // request byte stream
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    output logic rx_ready,
    // reply byte stream
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_last,
    input wire logic tx_ready,
    // register write port
    output logic reg_wr_en,
    output logic [15:0] reg_wr_addr,
    output logic [15:0] reg_wr_data,
    // register read port
    output logic reg_rd_en,
    output logic [15:0] reg_rd_addr,
    input wire logic [15:0] reg_rd_data,
    // object map lookup
    output logic [15:0] map_addr,
    output logic [15:0] map_count,
    input wire logic map_ok,
    // frame outcome
    output logic done_ok,
    output logic done_exc
);

    function automatic logic mbw_cnt_ok(input logic [15:0] cnt, input logic [15:0] max);
        mbw_cnt_ok = (cnt >= `MBW_CNT_MIN) && (cnt <= max);
    endfunction : mbw_cnt_ok

    mbw_rx_state_t st_r;
    logic [8:0] idx_r, bc_pos;
    logic [15:0] tid_r, pid_r, len_r, a1_r, c1_r, a2_r, c2_r, len_exp, wmax;
    logic [7:0] uid_r, fc_r, bc_r, exc_r, hi_byte_r, k_r;
    logic err_r, hi_r, is_rdwr, rx_fire, fmt_ok, last_word, drop;

    mbw_rsp_if rsp ();

    mbw_reply u_reply (
        .clk(clk),
        .rst_b(rst_b),
        .rsp(rsp),
        .tx_valid(tx_valid),
        .tx_data(tx_data),
        .tx_last(tx_last),
        .tx_ready(tx_ready),
        .reg_rd_en(reg_rd_en),
        .reg_rd_addr(reg_rd_addr),
        .reg_rd_data(reg_rd_data)
    );

    assign is_rdwr = (fc_r == `MBW_FC_RDWR);
    assign bc_pos = is_rdwr ? `MBW_POS_RW_BC : `MBW_POS_WR_BC;
    assign rx_ready = (st_r == S_HDR) || (st_r == S_DATA) || (st_r == S_DRAIN);
    assign rx_fire = rx_valid && rx_ready;
    assign last_word = !hi_r && ({8'h00, k_r} == c2_r - 16'h0001);
    // frames with a foreign protocol id get no reply
    assign drop = (pid_r != `MBW_PROTO_ID);

    // lookup of the write block, then of the read block
    assign map_addr = (st_r == S_MAPR) ? a1_r : a2_r;
    assign map_count = (st_r == S_MAPR) ? c1_r : c2_r;

    // expected length from the byte count
    always_comb begin
        if (is_rdwr) begin
            len_exp = `MBW_RW_LEN_BASE + {8'h00, bc_r};
            wmax = `MBW_RW_MAX;
        end else begin
            len_exp = `MBW_WR_LEN_BASE + {8'h00, bc_r};
            wmax = `MBW_WR_MAX;
        end
    end

    // count, byte count and length checks
    always_comb begin
        fmt_ok = mbw_cnt_ok(c2_r, wmax) && ({8'h00, bc_r} == {c2_r[14:0], 1'b0}) && (len_r == len_exp);
        if (is_rdwr && !mbw_cnt_ok(c1_r, `MBW_RW_MAX)) begin
            fmt_ok = 1'b0;
        end
    end

    // reply descriptor towards the builder
    assign rsp.start = (st_r == S_RESP) && !drop && !rsp.busy;
    assign rsp.err = err_r;
    assign rsp.exc = exc_r;
    assign rsp.tid = tid_r;
    assign rsp.uid = uid_r;
    assign rsp.fc = fc_r;
    assign rsp.rd_addr = a1_r;
    assign rsp.rd_cnt = c1_r;
    assign rsp.wr_addr = a2_r;
    assign rsp.wr_cnt = c2_r;

    // byte position within the fixed part of the frame
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            idx_r <= 9'h000;
        end else if (st_r != S_HDR) begin
            idx_r <= 9'h000;
        end else if (rx_fire) begin
            idx_r <= rx_last ? 9'h000 : idx_r + 9'h001;
        end
    end

    // header capture; field capture by position
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tid_r <= 16'h0000;
            pid_r <= 16'h0000;
            len_r <= 16'h0000;
            uid_r <= 8'h00;
            fc_r <= 8'h00;
            a1_r <= 16'h0000;
            c1_r <= 16'h0000;
            a2_r <= 16'h0000;
            c2_r <= 16'h0000;
            bc_r <= 8'h00;
        end else if (st_r == S_HDR && rx_fire) begin
            case (idx_r)
                9'h000: tid_r[15:8] <= rx_data;
                9'h001: tid_r[7:0] <= rx_data;
                9'h002: pid_r[15:8] <= rx_data;
                9'h003: pid_r[7:0] <= rx_data;
                9'h004: len_r[15:8] <= rx_data;
                9'h005: len_r[7:0] <= rx_data;
                9'h006: uid_r <= rx_data;
                9'h007: fc_r <= rx_data;
                9'h008: begin
                    if (is_rdwr) a1_r[15:8] <= rx_data;
                    else a2_r[15:8] <= rx_data;
                end
                9'h009: begin
                    if (is_rdwr) a1_r[7:0] <= rx_data;
                    else a2_r[7:0] <= rx_data;
                end
                9'h00a: begin
                    if (is_rdwr) c1_r[15:8] <= rx_data;
                    else c2_r[15:8] <= rx_data;
                end
                9'h00b: begin
                    if (is_rdwr) c1_r[7:0] <= rx_data;
                    else c2_r[7:0] <= rx_data;
                end
                9'h00c: begin
                    if (is_rdwr) a2_r[15:8] <= rx_data;
                    else bc_r <= rx_data;
                end
                9'h00d: a2_r[7:0] <= rx_data;
                9'h00e: c2_r[15:8] <= rx_data;
                9'h00f: c2_r[7:0] <= rx_data;
                9'h010: bc_r <= rx_data;
                default: ;
            endcase
        end
    end

    // frame sequencing and outcome
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_r <= S_HDR;
            err_r <= 1'b0;
            exc_r <= 8'h00;
        end else begin
            case (st_r)
                S_HDR: begin
                    if (rx_fire) begin
                        if (idx_r == `MBW_POS_FC && rx_data != `MBW_FC_WRITE && rx_data != `MBW_FC_RDWR) begin
                            err_r <= 1'b1;
                            exc_r <= `MBW_EXC_FUNC;
                            st_r <= rx_last ? S_RESP : S_DRAIN;
                        end else if (rx_last && idx_r >= `MBW_POS_FC) begin
                            err_r <= 1'b1;
                            exc_r <= `MBW_EXC_VALUE;
                            st_r <= S_RESP;
                        end else if (idx_r > `MBW_POS_FC && idx_r == bc_pos) begin
                            st_r <= S_CHK;
                        end
                    end
                end
                S_CHK: begin
                    if (!fmt_ok || drop) begin
                        err_r <= 1'b1;
                        exc_r <= `MBW_EXC_VALUE;
                        st_r <= S_DRAIN;
                    end else begin
                        st_r <= S_MAPW;
                    end
                end
                S_MAPW, S_MAPR: begin
                    if (!map_ok) begin
                        err_r <= 1'b1;
                        exc_r <= `MBW_EXC_ADDR;
                        st_r <= S_DRAIN;
                    end else if (st_r == S_MAPW && is_rdwr) begin
                        st_r <= S_MAPR;
                    end else begin
                        st_r <= S_DATA;
                    end
                end
                S_DATA: begin
                    if (rx_fire) begin
                        if (last_word) begin
                            if (!rx_last) begin
                                err_r <= 1'b1;
                                exc_r <= `MBW_EXC_VALUE;
                            end
                            st_r <= rx_last ? S_RESP : S_DRAIN;
                        end else if (rx_last) begin
                            err_r <= 1'b1;
                            exc_r <= `MBW_EXC_VALUE;
                            st_r <= S_RESP;
                        end
                    end
                end
                S_DRAIN: begin
                    if (rx_fire && rx_last) begin
                        st_r <= S_RESP;
                    end
                end
                S_RESP: begin
                    if (drop || !rsp.busy) begin
                        err_r <= 1'b0;
                        st_r <= S_HDR;
                    end
                end
                default: st_r <= S_HDR;
            endcase
        end
    end

    // write values as each word completes
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            hi_r <= 1'b1;
            k_r <= 8'h00;
            hi_byte_r <= 8'h00;
            reg_wr_en <= 1'b0;
            reg_wr_addr <= 16'h0000;
            reg_wr_data <= 16'h0000;
        end else begin
            reg_wr_en <= (st_r == S_DATA) && rx_fire && !hi_r;
            if (st_r != S_DATA) begin
                hi_r <= 1'b1;
                k_r <= 8'h00;
            end else if (rx_fire) begin
                hi_r <= !hi_r;
                if (hi_r) begin
                    hi_byte_r <= rx_data;
                end else begin
                    reg_wr_addr <= a2_r + {8'h00, k_r};
                    reg_wr_data <= {hi_byte_r, rx_data};
                    k_r <= k_r + 8'h01;
                end
            end
        end
    end

    // outcome pulses on handing the reply over
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            done_ok <= 1'b0;
            done_exc <= 1'b0;
        end else begin
            done_ok <= rsp.start && !err_r;
            done_exc <= rsp.start && err_r;
        end
    end

endmodule : mbw_handler

//--- dv/mbw_handler_props.sv
// assertion checker for the multi-register write handler
`timescale 1ns/1ps
module mbw_handler_props (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // reply stream
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    input wire logic tx_ready,
    // register ports and outcome
    input wire logic reg_wr_en,
    input wire logic [15:0] reg_wr_addr,
    input wire logic reg_rd_en,
    input wire logic done_ok,
    input wire logic done_exc
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    logic [8:0] tx_cnt_r;
    logic exc_r;
    logic wr_seen_r;
    logic [15:0] wr_last_r;

    // position of the byte on the reply stream
    always_ff @(posedge clk) begin
        if (!rst_b) tx_cnt_r <= 9'h000;
        else if (tx_valid && tx_ready) tx_cnt_r <= tx_last ? 9'h000 : tx_cnt_r + 9'h001;
    end
    always_ff @(posedge clk) begin
        if (!rst_b) exc_r <= 1'b0;
        else if (done_exc) exc_r <= 1'b1;
        else if (done_ok) exc_r <= 1'b0;
    end
    always_ff @(posedge clk) begin
        if (!rst_b || done_ok || done_exc) wr_seen_r <= 1'b0;
        else if (reg_wr_en) wr_seen_r <= 1'b1;
    end
    always_ff @(posedge clk) begin
        if (reg_wr_en) wr_last_r <= reg_wr_addr;
    end

    a_wr_consec: assert property (reg_wr_en && wr_seen_r |-> reg_wr_addr == wr_last_r + 16'h0001)
        else $error("write address not consecutive");
    a_wr_pulse: assert property (reg_wr_en |=> !reg_wr_en)
        else $error("write strobe longer than one cycle");
    a_rd_spacing: assert property (reg_rd_en |=> !reg_rd_en [*2])
        else $error("reads issued too close");
    a_done_excl: assert property (!(done_ok && done_exc))
        else $error("normal and exception outcome together");
    a_reply_start: assert property ((done_ok || done_exc) |-> ##[0:3] tx_valid)
        else $error("reply did not start");
    a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
        else $error("reply byte changed while stalled");
    a_pid_zero: assert property (tx_valid && (tx_cnt_r == 9'h002 || tx_cnt_r == 9'h003) |-> tx_data == 8'h00)
        else $error("protocol id not zero");
    a_len_high: assert property (tx_valid && tx_cnt_r == 9'h004 |-> tx_data == 8'h00)
        else $error("length high byte not zero");
    a_exc_len: assert property (tx_valid && exc_r && tx_cnt_r == 9'h005 |-> tx_data == 8'h03)
        else $error("exception length wrong");
    a_exc_flag: assert property (tx_valid && exc_r && tx_cnt_r == 9'h007 |-> tx_data[7] && !tx_last)
        else $error("exception error code wrong");
    a_exc_end: assert property (tx_valid && exc_r && tx_cnt_r == 9'h008 |-> tx_last && tx_data inside {[8'h01:8'h04]})
        else $error("exception code wrong");

    c_ok: cover property (done_ok);
    c_exc: cover property (done_exc);
    c_stall: cover property (tx_valid && !tx_ready);
    c_read: cover property (reg_rd_en);
endmodule : mbw_handler_props

bind mbw_handler mbw_handler_props u_props (.clk(clk), .rst_b(rst_b), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready), .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr),
    .reg_rd_en(reg_rd_en), .done_ok(done_ok), .done_exc(done_exc));

//--- dv/mbw_client_model.sv
// client model: sends request frames, collects reply bytes
`timescale 1ns/1ps
module mbw_client_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // request stream
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_last,
    input wire logic rx_ready,
    // reply stream
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    output logic tx_ready
);
    logic [7:0] rsp_q[$];
    logic slow = 1'b0;
    int replies = 0;

    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_last = 1'b0;
    end

    // header then body, byte by byte
    task automatic send(input logic [7:0] f[$]);
        for (int i = 0; i < f.size(); i++) begin
            rx_valid <= 1'b1;
            rx_data <= f[i];
            rx_last <= (i == f.size() - 1);
            @(posedge clk);
            while (!rx_ready) @(posedge clk);
        end
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
        rx_data <= ~f[f.size() - 1];
    endtask : send

    // reply sink, stalls every other cycle when slow
    always @(posedge clk) begin
        if (rst_b && tx_valid && tx_ready) begin
            rsp_q.push_back(tx_data);
            if (tx_last) replies++;
        end
        tx_ready <= slow ? ~tx_ready : 1'b1;
    end
endmodule : mbw_client_model

//--- dv/mbw_handler_tb_top.sv
// testbench for the multi-register write handler
`timescale 1ns/1ps
module mbw_handler_tb_top;
    typedef logic [7:0] mbw_bq_t[$];
    logic clk;
    logic rst_b;
    logic rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
    logic [7:0] rx_data, tx_data;
    logic reg_wr_en, reg_rd_en, map_ok, done_ok, done_exc;
    logic [15:0] reg_wr_addr, reg_wr_data, reg_rd_addr, reg_rd_data, map_addr, map_count;
    logic [15:0] tid;
    logic [31:0] wr_q[$];
    int failures = 0;
    int checks = 0;
    int cycles = 0;

    mbw_handler dut (.clk, .rst_b, .rx_valid, .rx_data, .rx_last, .rx_ready, .tx_valid, .tx_data, .tx_last,
        .tx_ready, .reg_wr_en, .reg_wr_addr, .reg_wr_data, .reg_rd_en, .reg_rd_addr, .reg_rd_data,
        .map_addr, .map_count, .map_ok, .done_ok, .done_exc);
    mbw_client_model client (.clk, .rst_b, .rx_valid, .rx_data, .rx_last, .rx_ready, .tx_valid, .tx_data,
        .tx_last, .tx_ready);

    // blocks at 0xf000 and up are not mapped
    assign map_ok = (map_addr[15:12] != 4'hf);
    always @(posedge clk) begin
        if (reg_rd_en) reg_rd_data <= reg_rd_addr ^ 16'ha5a5;
        if (reg_wr_en) wr_q.push_back({reg_wr_addr, reg_wr_data});
    end

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            test_done();
        end
    end

    task automatic test_done();
        if (failures == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    function automatic mbw_bq_t mk(input logic [7:0] fc, input mbw_bq_t body, input logic [7:0] adj);
        logic [15:0] len;
        tid = tid + 16'h0001;
        len = 16'(body.size() + 2) + {8'h00, adj};
        mk = {tid[15:8], tid[7:0], 8'h00, 8'h00, len[15:8], len[7:0], 8'h05, fc};
        foreach (body[i]) mk.push_back(body[i]);
    endfunction : mk

    function automatic mbw_bq_t rsp(input logic [15:0] len, input logic [7:0] fc, input mbw_bq_t body);
        rsp = {tid[15:8], tid[7:0], 8'h00, 8'h00, len[15:8], len[7:0], 8'h05, fc};
        foreach (body[i]) rsp.push_back(body[i]);
    endfunction : rsp

    task automatic xfer(input mbw_bq_t f, output mbw_bq_t r);
        int n;
        n = client.replies;
        client.rsp_q.delete();
        wr_q.delete();
        client.send(f);
        for (int i = 0; i < 2000 && client.replies == n; i++) @(posedge clk);
        r = client.rsp_q;
    endtask : xfer

    task automatic cmpq(input mbw_bq_t r, input mbw_bq_t e);
        chk(32'(r.size()), 32'(e.size()));
        for (int i = 0; i < e.size() && i < r.size(); i++) chk({24'h0, r[i]}, {24'h0, e[i]});
    endtask : cmpq

    task automatic t_write();
        mbw_bq_t r;
        @(posedge clk);
        xfer(mk(8'h10, {8'h17, 8'h70, 8'h00, 8'h02, 8'h04, 8'h01, 8'h02, 8'h03, 8'h04}, 8'h00), r);
        cmpq(r, rsp(16'h0006, 8'h10, {8'h17, 8'h70, 8'h00, 8'h02}));
        chk(32'(wr_q.size()), 32'd2);
        chk(wr_q[0], 32'h1770_0102);
        chk(wr_q[1], 32'h1771_0304);
    endtask : t_write

    task automatic t_wmax();
        mbw_bq_t r, b;
        @(posedge clk);
        b = {8'h00, 8'h20, 8'h00, 8'h7b, 8'hf6};
        for (int i = 0; i < 246; i++) b.push_back(8'(i));
        xfer(mk(8'h10, b, 8'h00), r);
        cmpq(r, rsp(16'h0006, 8'h10, {8'h00, 8'h20, 8'h00, 8'h7b}));
        chk(32'(wr_q.size()), 32'd123);
        chk(wr_q[122], 32'h009a_f4f5);
    endtask : t_wmax

    task automatic t_rdwr();
        mbw_bq_t r, e;
        logic [15:0] v;
        @(posedge clk);
        client.slow = 1'b1;
        e = {8'hf2};
        for (int i = 0; i < 121; i++) begin
            v = (16'h1388 + 16'(i)) ^ 16'ha5a5;
            e.push_back(v[15:8]);
            e.push_back(v[7:0]);
        end
        xfer(mk(8'h17, {8'h13, 8'h88, 8'h00, 8'h79, 8'h17, 8'h70, 8'h00, 8'h01, 8'h02, 8'hab, 8'hcd}, 8'h00), r);
        client.slow = 1'b0;
        cmpq(r, rsp(16'h00f5, 8'h17, e));
        chk(32'(wr_q.size()), 32'd1);
        chk(wr_q[0], 32'h1770_abcd);
    endtask : t_rdwr

    task automatic t_exc(input logic [7:0] fc, input mbw_bq_t body, input logic [7:0] adj, input logic [7:0] code);
        mbw_bq_t r;
        @(posedge clk);
        xfer(mk(fc, body, adj), r);
        cmpq(r, rsp(16'h0003, fc | 8'h80, {code}));
        chk(32'(wr_q.size()), 32'd0);
    endtask : t_exc

    task automatic t_errors();
        t_exc(8'h10, {8'h00, 8'h10, 8'h00, 8'h00, 8'h00}, 8'h00, 8'h03);
        t_exc(8'h10, {8'h00, 8'h10, 8'h00, 8'h7c, 8'hf8, 8'haa}, 8'hf7, 8'h03);
        t_exc(8'h10, {8'h00, 8'h10, 8'h00, 8'h01, 8'h03, 8'haa, 8'hbb}, 8'h00, 8'h03);
        t_exc(8'h10, {8'h00, 8'h10, 8'h00, 8'h01, 8'h02, 8'haa, 8'hbb}, 8'h01, 8'h03);
        t_exc(8'h17, {8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h20, 8'h00, 8'h01, 8'h02, 8'haa, 8'hbb}, 8'h00, 8'h03);
        t_exc(8'h17, {8'h00, 8'h10, 8'h00, 8'h7a, 8'h00, 8'h20, 8'h00, 8'h01, 8'h02, 8'haa, 8'hbb}, 8'h00, 8'h03);
        t_exc(8'h17, {8'h00, 8'h10, 8'h00, 8'h01, 8'h00, 8'h20, 8'h00, 8'h7a, 8'hf4, 8'haa}, 8'hf3, 8'h03);
        t_exc(8'h17, {8'h00, 8'h10, 8'h00, 8'h01, 8'h00, 8'h20, 8'h00, 8'h01, 8'h04, 8'haa, 8'hbb}, 8'h00, 8'h03);
        t_exc(8'h17, {8'h00, 8'h10, 8'h00, 8'h01, 8'h00, 8'h20, 8'h00, 8'h01, 8'h02, 8'haa, 8'hbb}, 8'h02, 8'h03);
        t_exc(8'h10, {8'hf0, 8'h00, 8'h00, 8'h01, 8'h02, 8'haa, 8'hbb}, 8'h00, 8'h02);
        t_exc(8'h17, {8'hf0, 8'h00, 8'h00, 8'h01, 8'h00, 8'h20, 8'h00, 8'h01, 8'h02, 8'haa, 8'hbb}, 8'h00, 8'h02);
        t_exc(8'h03, {8'h00, 8'h10, 8'h00, 8'h01}, 8'h00, 8'h01);
    endtask : t_errors

    task automatic t_pid();
        mbw_bq_t f;
        int n;
        @(posedge clk);
        f = mk(8'h10, {8'h00, 8'h30, 8'h00, 8'h01, 8'h02, 8'h11, 8'h22}, 8'h00);
        f[2] = 8'h01;
        n = client.replies;
        wr_q.delete();
        client.send(f);
        repeat (40) @(posedge clk);
        chk(32'(client.replies), 32'(n));
        chk(32'(wr_q.size()), 32'd0);
    endtask : t_pid

    initial begin
        tid = 16'h1234;
        rst_b = 1'b0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        t_write();
        t_wmax();
        t_rdwr();
        t_errors();
        t_pid();
        t_write();
        test_done();
    end
endmodule : mbw_handler_tb_top
